//--- shared/kli_pkg.sv
package kli_pkg;

    // ------------------------------------------------------------
    // Register addresses on the special function register bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h9C;
    localparam logic [7:0] ADDR_LINE_ENABLE  = 8'h9D;
    localparam logic [7:0] ADDR_LINE_FLAGS   = 8'h9E;
    localparam logic [7:0] ADDR_IRQ_ENABLE2  = 8'hB1;
    localparam logic [7:0] ADDR_PRIO_LOW2    = 8'hB2;
    localparam logic [7:0] ADDR_PRIO_HIGH2   = 8'hB3;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          NUM_LINES        = 8;
    localparam int          GLOBAL_EN_BIT    = 0;
    localparam int          PRIO_BIT         = 0;
    localparam int          SW_CLEAR_LINE    = 2;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [7:0]  READ_CLEAR_MASK  = 8'hFB;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
    localparam logic [7:0]  PIN_IDLE_BYTE    = 8'hFF;

    // ------------------------------------------------------------
    // Complete state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
        logic [7:0] level_select_bits;
        logic [7:0] line_enable_bits;
        logic [7:0] line_flag_bits;
        logic       global_keypad_enable_bit;
        logic       keypad_priority_low;
        logic       keypad_priority_high;
        logic [7:0] rdata;
        logic       irq;
        logic       wake;
    } kli_state_s;

endpackage

//--- hdl/kli_keypad_level_interrupt.sv
`timescale 1ns/10ps
// Function
// - Eight port inputs are separate sources sharing one interrupt request.
// - Level-select bit zero makes a low input the active level.
// - Level-select bit one makes a high input the active level.
// - Hardware sets each line flag while its input shows active level.
// - A flag requests an interrupt only while its line enable is one.
// - Reading the flag register clears flags of lines 0, 1 and 3-7.
// - A disabled line contributes nothing and stays an ordinary pin.
// - One global enable gates the combined request of all lines.
// - Active level on an enabled line wakes from idle and power-down.
// - Level-select, enable and flag registers reset to zero.
// - Global enable is bit 0 of the second interrupt enable register.
// - Two priority bits give four levels, 00 lowest, 11 highest.
module kli_keypad_level_interrupt (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] keypad_port_pins_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    output logic            keypad_interrupt_request_o,
    output logic      [1:0] keypad_priority_o,
    output logic            wake_request_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    kli_pkg::kli_state_s st;
    kli_pkg::kli_state_s next_st;

    logic [7:0] active_level;
    logic       wr_level;
    logic       wr_enable;
    logic       wr_flags;
    logic       wr_ien;
    logic       wr_plow;
    logic       wr_phigh;
    logic       rd_flags;

    // ------------------------------------------------------------
    // Per-line level compare
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < kli_pkg::NUM_LINES; g++) begin : g_line
            // XNOR: low matches when select is 0, high when 1
            assign active_level[g] =
                ~(st.pin_sync[g] ^ st.level_select_bits[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign wr_level  = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_LEVEL_SELECT);
    assign wr_enable = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_LINE_ENABLE);
    assign wr_flags  = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_LINE_FLAGS);
    assign wr_ien    = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_IRQ_ENABLE2);
    assign wr_plow   = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_PRIO_LOW2);
    assign wr_phigh  = sfr_wr_i && (sfr_addr_i == kli_pkg::ADDR_PRIO_HIGH2);
    assign rd_flags  = sfr_rd_i && (sfr_addr_i == kli_pkg::ADDR_LINE_FLAGS);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] clr;
        clr     = kli_pkg::ZERO_BYTE;
        next_st = st;

        // Meta stage feeds only the second stage
        next_st.pin_meta = keypad_port_pins_i;
        next_st.pin_sync = st.pin_meta;

        if (wr_level) begin
            next_st.level_select_bits = sfr_wdata_i;
        end
        if (wr_enable) begin
            next_st.line_enable_bits = sfr_wdata_i;
        end
        if (wr_ien) begin
            next_st.global_keypad_enable_bit =
                sfr_wdata_i[kli_pkg::GLOBAL_EN_BIT];
        end
        if (wr_plow) begin
            next_st.keypad_priority_low = sfr_wdata_i[kli_pkg::PRIO_BIT];
        end
        if (wr_phigh) begin
            next_st.keypad_priority_high = sfr_wdata_i[kli_pkg::PRIO_BIT];
        end

        // Read clears all but the software-cleared line
        if (rd_flags) begin
            clr = kli_pkg::READ_CLEAR_MASK;
        end
        if (wr_flags && !sfr_wdata_i[kli_pkg::SW_CLEAR_LINE]) begin
            clr[kli_pkg::SW_CLEAR_LINE] = 1'b1;
        end
        // Set wins over clear so a held key is never lost
        next_st.line_flag_bits =
            (st.line_flag_bits & ~clr) | active_level;

        // Read data shows flags before the clear takes hold
        case (sfr_addr_i)
            kli_pkg::ADDR_LEVEL_SELECT: next_st.rdata = st.level_select_bits;
            kli_pkg::ADDR_LINE_ENABLE:  next_st.rdata = st.line_enable_bits;
            kli_pkg::ADDR_LINE_FLAGS:   next_st.rdata = st.line_flag_bits;
            kli_pkg::ADDR_IRQ_ENABLE2: begin
                next_st.rdata = kli_pkg::ZERO_BYTE;
                next_st.rdata[kli_pkg::GLOBAL_EN_BIT] =
                    st.global_keypad_enable_bit;
            end
            kli_pkg::ADDR_PRIO_LOW2: begin
                next_st.rdata = kli_pkg::ZERO_BYTE;
                next_st.rdata[kli_pkg::PRIO_BIT] = st.keypad_priority_low;
            end
            kli_pkg::ADDR_PRIO_HIGH2: begin
                next_st.rdata = kli_pkg::ZERO_BYTE;
                next_st.rdata[kli_pkg::PRIO_BIT] = st.keypad_priority_high;
            end
            default: next_st.rdata = kli_pkg::ZERO_BYTE;
        endcase
        if (!sfr_rd_i) begin
            next_st.rdata = st.rdata;
        end

        // One shared request, masked per line, gated globally
        next_st.irq = st.global_keypad_enable_bit
            && |(st.line_flag_bits & st.line_enable_bits);
        // Disabled lines neither request nor wake
        next_st.wake =
            |(active_level & st.line_enable_bits);

        if (!nrst_i) begin
            next_st = '0;
            // Released keys pull high; a low reset would flag every line
            next_st.pin_meta = kli_pkg::PIN_IDLE_BYTE;
            next_st.pin_sync = kli_pkg::PIN_IDLE_BYTE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfr_rdata_o                = st.rdata;
    assign keypad_interrupt_request_o = st.irq;
    assign keypad_priority_o          =
        {st.keypad_priority_high, st.keypad_priority_low};
    assign wake_request_o             = st.wake;

endmodule // kli_keypad_level_interrupt

//--- tb/kli_keypad_model.sv
`timescale 1ns/10ps
module kli_keypad_model (
    input  wire logic [7:0] key_down_i,
    output logic      [7:0] keypad_port_pins_o
);
    // Pull-ups hold released lines high, a pressed key grounds its line
    assign keypad_port_pins_o = ~key_down_i;
endmodule // kli_keypad_model

//--- tb/kli_monitor.sv
`timescale 1ns/10ps
module kli_monitor (
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] keypad_port_pins_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       keypad_interrupt_request_o,
    input wire logic       wake_request_o,
    input wire logic [1:0] keypad_priority_o
);
    wire irq = keypad_interrupt_request_o;
    wire w1 = sfr_wr_i && sfr_addr_i == kli_pkg::ADDR_IRQ_ENABLE2;
    wire w2 = sfr_wr_i && sfr_addr_i == kli_pkg::ADDR_PRIO_LOW2;
    wire w3 = sfr_wr_i && sfr_addr_i == kli_pkg::ADDR_PRIO_HIGH2;
    wire we = sfr_wr_i && sfr_addr_i == kli_pkg::ADDR_LINE_ENABLE;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_rst;
        disable iff (1'b0) !nrst_i |=> !irq && keypad_priority_o == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_glob; w1 && !sfr_wdata_i[0] |=> ##1 !irq; endproperty
    a_glob: assert property (p_glob) else $error("irq not gated");
    property p_en; we && sfr_wdata_i == 8'h00 |=> ##1 !irq; endproperty
    a_en: assert property (p_en) else $error("irq while masked");
    property p_wk; we && sfr_wdata_i == 8'h00 |=> ##1 !wake_request_o;
    endproperty
    a_wk: assert property (p_wk) else $error("wake while masked");
    property p_lo; w2
        |=> keypad_priority_o[0] == $past(sfr_wdata_i[0]); endproperty
    a_lo: assert property (p_lo) else $error("low prio bit");
    property p_hi; w3
        |=> keypad_priority_o[1] == $past(sfr_wdata_i[0]); endproperty
    a_hi: assert property (p_hi) else $error("high prio bit");
    property p_rsv; sfr_rd_i && sfr_addr_i == kli_pkg::ADDR_IRQ_ENABLE2
        |=> sfr_rdata_o[7:1] == 7'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
endmodule // kli_monitor
bind kli_keypad_level_interrupt kli_monitor mon_u (.*);

//--- tb/kli_keypad_level_interrupt_tb.sv
`timescale 1ns/10ps
module kli_keypad_level_interrupt_tb;
    logic       clk_sys_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, key = 8'h00, pins, rdata;
    logic       irq, wake;
    logic [1:0] prio;
    logic [7:0] ra [6] = '{8'h9C, 8'h9D, 8'hB1, 8'hB2, 8'hB3, 8'hA0};
    int         num_errors = 0;
    int         samples_checked = 0;
    initial forever #2 clk_sys_i = ~clk_sys_i;
    kli_keypad_model key_u (.key_down_i(key), .keypad_port_pins_o(pins));
    kli_keypad_level_interrupt dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .keypad_port_pins_i(pins), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .keypad_interrupt_request_o(irq), .keypad_priority_o(prio),
        .wake_request_o(wake));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pin(input logic [7:0] k, input int n);
        @(posedge clk_sys_i);
        key <= k;
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic summarize;
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        addr <= kli_pkg::ADDR_LINE_FLAGS;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk(rdata, 8'h00);
        foreach (ra[i]) r(ra[i], 8'h00);
        // Idle pins read high, so no flag rises after reset
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
        pin(8'h04, 6);
        pin(8'h00, 6);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h04);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h04);
        w(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
        w(kli_pkg::ADDR_LINE_ENABLE, 8'h01);
        w(kli_pkg::ADDR_IRQ_ENABLE2, 8'hFF);
        r(kli_pkg::ADDR_IRQ_ENABLE2, 8'h01);
        pin(8'h09, 6);
        chk({6'h00, irq, wake}, 8'h03);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h09);
        w(kli_pkg::ADDR_IRQ_ENABLE2, 8'h00);
        pin(8'h09, 2);
        chk({6'h00, irq, wake}, 8'h01);
        w(kli_pkg::ADDR_LINE_ENABLE, 8'h00);
        pin(8'h00, 6);
        chk({6'h00, irq, wake}, 8'h00);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h09);
        w(kli_pkg::ADDR_LEVEL_SELECT, 8'h80);
        w(kli_pkg::ADDR_LINE_ENABLE, 8'h80);
        w(kli_pkg::ADDR_IRQ_ENABLE2, 8'h01);
        pin(8'h00, 6);
        chk({6'h00, irq, wake}, 8'h03);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h80);
        pin(8'h80, 6);
        r(kli_pkg::ADDR_LINE_FLAGS, 8'h80);
        pin(8'h80, 2);
        chk({6'h00, irq, wake}, 8'h00);
        for (int p = 0; p < 4; p++) begin
            w(kli_pkg::ADDR_PRIO_LOW2, {7'h00, p[0]});
            w(kli_pkg::ADDR_PRIO_HIGH2, {7'h00, p[1]});
            pin(8'h80, 1);
            chk({6'h00, prio}, p[7:0]);
        end
        summarize();
    end
endmodule // kli_keypad_level_interrupt_tb
